// >>> verilog/flacd_defs.svh
// offsets, field positions, reset values and loop constants of the audio clock divider
`ifndef FLACD_DEFS_SVH
`define FLACD_DEFS_SVH

`define FLACD_OFS_CPF_LOW 8'h30
`define FLACD_OFS_CPF_MID 8'h31
`define FLACD_OFS_CPF_HIGH 8'h32
`define FLACD_OFS_INC_LOW 8'h34
`define FLACD_OFS_INC_MID 8'h35
`define FLACD_OFS_INC_HIGH 8'h36
`define FLACD_OFS_BCLK_DIV 8'h38
`define FLACD_OFS_LRCLK_DIV 8'h39
`define FLACD_OFS_CTRL 8'h3a

`define FLACD_CPF_W 18
`define FLACD_INC_W 22
`define FLACD_DIV_W 6
`define FLACD_ACC_W 23
`define FLACD_TRIM_W 8

`define FLACD_BIT_LOOP_OPEN 3
`define FLACD_BIT_VREF_SEL 2
`define FLACD_BIT_LR_PHASE 1
`define FLACD_BIT_BCLK_PHASE 0

`define FLACD_RST_BCLK_DIV 6'h03
`define FLACD_RST_LRCLK_DIV 6'h10
`define FLACD_RST_CTRL 4'h0
`define FLACD_TRIM_MAX 8'sh7f
`define FLACD_TRIM_MIN (-8'sh7f)

`endif

// >>> verilog/flacd_pkg.sv
// types shared by the audio clock divider modules
`default_nettype none
package flacd_pkg;
  `include "flacd_defs.svh"
  typedef logic [`FLACD_DIV_W-1:0] flacd_div_t;
  typedef logic signed [`FLACD_TRIM_W-1:0] flacd_trim_t;
endpackage
`default_nettype wire

// >>> verilog/flacd_div_if.sv
// carrier between the control top and the clock division chain
`default_nettype none
interface flacd_div_if;
  import flacd_pkg::*;
  logic ce;
  logic mclk_lvl;
  logic bclk_phase;
  logic lr_phase;
  flacd_div_t bclk_div;
  flacd_div_t lrclk_div;
  logic bclk;
  logic lrclk;
  modport ctrl (output ce, mclk_lvl, bclk_phase, lr_phase, bclk_div, lrclk_div,
                input bclk, lrclk);
  modport chain (input ce, mclk_lvl, bclk_phase, lr_phase, bclk_div, lrclk_div,
                 output bclk, lrclk);
endinterface
`default_nettype wire

// >>> verilog/flacd_div.sv
// binary division of the master clock into bit clock and channel clock
`default_nettype none
module flacd_div
  import flacd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  flacd_div_if.chain dv
);
  logic mclk_prev_q;
  logic bclk_q;
  logic lrclk_q;
  flacd_div_t bcnt_q;
  flacd_div_t lcnt_q;
  logic m_edge;
  logic b_edge;

  // selected master edge: falling when phase bit is 0, rising when 1
  assign m_edge = dv.bclk_phase ? (dv.mclk_lvl & ~mclk_prev_q)
                                : (~dv.mclk_lvl & mclk_prev_q);
  // bit clock edge that moves the channel clock, judged on the new level
  assign b_edge = m_edge && (bcnt_q >= dv.bclk_div) &&
                  (dv.lr_phase ? ~bclk_q : bclk_q);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_prev_q <= 1'b0;
    end else if (dv.ce) begin
      mclk_prev_q <= dv.mclk_lvl;
    end
  end

  // half period of bit_clock_divider+1 master edges gives fm / (2*(bit_clock_divider+1))
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bcnt_q <= '0;
      bclk_q <= 1'b0;
    end else if (dv.ce && m_edge) begin
      if (bcnt_q >= dv.bclk_div) begin
        bcnt_q <= '0;
        bclk_q <= ~bclk_q;
      end else begin
        bcnt_q <= bcnt_q + 6'h01;
      end
    end
  end

  // half period of channel_clock_divider bit clock edges gives fb / (2*channel_clock_divider); 0 acts as 1
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lcnt_q <= '0;
      lrclk_q <= 1'b0;
    end else if (dv.ce && b_edge) begin
      if (lcnt_q + 6'h01 >= dv.lrclk_div) begin
        lcnt_q <= '0;
        lrclk_q <= ~lrclk_q;
      end else begin
        lcnt_q <= lcnt_q + 6'h01;
      end
    end
  end

  assign dv.bclk = bclk_q;
  assign dv.lrclk = lrclk_q;
endmodule
`default_nettype wire

// >>> verilog/flacd_top.sv
// field-locked audio master clock synthesis with register file and divider chain
`default_nettype none
// How it works
// - bit clock equals master input over two times (bit divisor plus one).
// - channel clock equals bit clock over two times channel divisor.
// - both clocks come from plain binary counting of edges.
// - divider master clock comes from its own pin, normally looped from master out.
// - master clock trimmed slowly to field rate; loop open bit stops trimming.
// - vertical reference is internal when select is 0, external pin when 1.
// - channel clock moves on falling bit clock edges at phase 0, rising at 1.
// - bit clock moves on falling master edges at phase 0, rising at 1.
// - synthesized master audio clock is driven on its own output.
// - clocks per field is 18 bits over low, mid and two high bits.
// - nominal increment is 22 bits over low, mid and six high bits.
// - master clock is an accumulator on the reference, increment scaled 2^23.
module flacd_top
  import flacd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic internal_vsync_i,
  input wire logic external_vsync_i,
  input wire logic divider_master_clock_in,
  output logic master_audio_clock_out,
  output logic audio_bit_clock_out,
  output logic channel_select_clock_out
);
  logic [`FLACD_CPF_W-1:0] cpf_q;
  logic [`FLACD_INC_W-1:0] inc_q;
  flacd_div_t bdiv_q;
  flacd_div_t ldiv_q;
  logic [3:0] ctrl_q;
  logic [7:0] rdata_q;
  logic [`FLACD_ACC_W-1:0] acc_q;
  logic [`FLACD_ACC_W-1:0] step;
  flacd_trim_t trim_q;
  logic [`FLACD_CPF_W-1:0] fcnt_q;
  logic mclk_prev_q;
  logic m_rise;
  logic [1:0] async_in;
  logic [1:0] sync_a_q;
  logic [1:0] sync_b_q;
  logic [`FLACD_ACC_W:0] step_wide;
  logic wr_go;
  logic vref_prev_q;
  logic vref;
  logic v_edge;
  logic loop_open;

  flacd_div_if dv ();

  assign wr_go = clk_en_i && reg_wr_i;

  // undocumented reset values chosen to give a running chain; each byte takes effect alone
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpf_q <= '0;
    end else if (wr_go) begin
      case (reg_addr_i)
        `FLACD_OFS_CPF_LOW: cpf_q[7:0] <= reg_wdata_i;
        `FLACD_OFS_CPF_MID: cpf_q[15:8] <= reg_wdata_i;
        `FLACD_OFS_CPF_HIGH: cpf_q[17:16] <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inc_q <= '0;
    end else if (wr_go) begin
      case (reg_addr_i)
        `FLACD_OFS_INC_LOW: inc_q[7:0] <= reg_wdata_i;
        `FLACD_OFS_INC_MID: inc_q[15:8] <= reg_wdata_i;
        `FLACD_OFS_INC_HIGH: inc_q[21:16] <= reg_wdata_i[5:0];
        default: ;
      endcase
    end
  end

  // a divisor change is picked up at the next count compare, so no glitch handling here
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bdiv_q <= `FLACD_RST_BCLK_DIV;
      ldiv_q <= `FLACD_RST_LRCLK_DIV;
    end else if (wr_go) begin
      case (reg_addr_i)
        `FLACD_OFS_BCLK_DIV: bdiv_q <= reg_wdata_i[5:0];
        `FLACD_OFS_LRCLK_DIV: ldiv_q <= reg_wdata_i[5:0];
        default: ;
      endcase
    end
  end

  // control bits act on the next edge; the chain reads the phase bits directly
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `FLACD_RST_CTRL;
    end else if (wr_go && (reg_addr_i == `FLACD_OFS_CTRL)) begin
      ctrl_q <= reg_wdata_i[3:0];
    end
  end

  // reads answer one cycle after the strobe; unused bits and offsets read zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        `FLACD_OFS_CPF_LOW: rdata_q <= cpf_q[7:0];
        `FLACD_OFS_CPF_MID: rdata_q <= cpf_q[15:8];
        `FLACD_OFS_CPF_HIGH: rdata_q <= {6'h00, cpf_q[17:16]};
        `FLACD_OFS_INC_LOW: rdata_q <= inc_q[7:0];
        `FLACD_OFS_INC_MID: rdata_q <= inc_q[15:8];
        `FLACD_OFS_INC_HIGH: rdata_q <= {2'h0, inc_q[21:16]};
        `FLACD_OFS_BCLK_DIV: rdata_q <= {2'h0, bdiv_q};
        `FLACD_OFS_LRCLK_DIV: rdata_q <= {2'h0, ldiv_q};
        `FLACD_OFS_CTRL: rdata_q <= {4'h0, ctrl_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_o = rdata_q;

  // pins from other domains pass two flops; only the second stage is read
  assign async_in = {external_vsync_i, divider_master_clock_in};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        sync_a_q[g] <= 1'b0;
        sync_b_q[g] <= 1'b0;
      end else if (clk_en_i) begin
        sync_a_q[g] <= async_in[g];
        sync_b_q[g] <= sync_a_q[g];
      end
    end
  end

  assign loop_open = ctrl_q[`FLACD_BIT_LOOP_OPEN];
  // internal vertical comes from logic on this clock, so no synchroniser
  assign vref = ctrl_q[`FLACD_BIT_VREF_SEL] ? sync_b_q[1] : internal_vsync_i;
  assign v_edge = vref & ~vref_prev_q;

  // accumulator carry rate is inc/2^23 of the reference, msb is the clock
  // a negative trim beyond the increment would wrap to a huge step, so the step stops at zero
  assign step_wide = {2'b00, inc_q} + {{(`FLACD_ACC_W+1-`FLACD_TRIM_W){trim_q[7]}}, trim_q};
  assign step = step_wide[`FLACD_ACC_W] ? '0 : step_wide[`FLACD_ACC_W-1:0];
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q <= '0;
    end else if (clk_en_i) begin
      acc_q <= acc_q + step;
    end
  end
  assign master_audio_clock_out = acc_q[`FLACD_ACC_W-1];

  // previous levels for the master and field edge detectors
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_prev_q <= 1'b0;
      vref_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      mclk_prev_q <= acc_q[`FLACD_ACC_W-1];
      vref_prev_q <= vref;
    end
  end
  assign m_rise = acc_q[`FLACD_ACC_W-1] & ~mclk_prev_q;

  // master clocks counted per field against the programmed target; saturates on a lost field
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fcnt_q <= '0;
    end else if (clk_en_i) begin
      if (v_edge) begin
        fcnt_q <= '0;
      end else if (m_rise && (fcnt_q != '1)) begin
        fcnt_q <= fcnt_q + 18'h00001;
      end
    end
  end

  // one step of trim per field keeps the loop very slow and free of jitter
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trim_q <= '0;
    end else if (clk_en_i) begin
      if (loop_open) begin
        trim_q <= '0;
      end else if (v_edge) begin
        if (fcnt_q > cpf_q && trim_q != `FLACD_TRIM_MIN) begin
          trim_q <= trim_q - 8'sh01;
        end else if (fcnt_q < cpf_q && trim_q != `FLACD_TRIM_MAX) begin
          trim_q <= trim_q + 8'sh01;
        end
      end
    end
  end

  // the chain freezes with the rest of the block while the enable is low
  assign dv.ce = clk_en_i;
  assign dv.mclk_lvl = sync_b_q[0];
  assign dv.bclk_phase = ctrl_q[`FLACD_BIT_BCLK_PHASE];
  assign dv.lr_phase = ctrl_q[`FLACD_BIT_LR_PHASE];
  assign dv.bclk_div = bdiv_q;
  assign dv.lrclk_div = ldiv_q;

  flacd_div u_div (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .dv(dv.chain)
  );

  assign audio_bit_clock_out = dv.bclk;
  assign channel_select_clock_out = dv.lrclk;
endmodule
`default_nettype wire

// >>> verification/flacd_asserts.sv
// port checks for the audio clock divider
`default_nettype none
module flacd_asserts (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic divider_master_clock_in,
  input wire logic audio_bit_clock_out,
  input wire logic channel_select_clock_out
);
  logic [3:0] ctl_q;
  // shadow of the control bits, built from the write strobe alone
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= 4'h0;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == 8'h3a) begin
      ctl_q <= reg_wdata_i[3:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence rd_req;
    clk_en_i && reg_rd_i;
  endsequence
  sequence lr_move;
    $changed(channel_select_clock_out);
  endsequence
  rdata_hold_a: assert property (
    !(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o)) else $error("read data moved");
  rd_unmapped_a: assert property (
    rd_req ##0 (reg_addr_i > 8'h3a || reg_addr_i < 8'h30) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  inc_pad_a: assert property (
    rd_req ##0 reg_addr_i == 8'h36 |=> reg_rdata_o[7:6] == 2'h0) else $error("inc pad");
  div_pad_a: assert property (
    rd_req ##0 reg_addr_i[7:1] == 7'h1c |=> reg_rdata_o[7:6] == 2'h0) else $error("div pad");
  ctrl_read_a: assert property (
    rd_req ##0 reg_addr_i == 8'h3a && !reg_wr_i |=> reg_rdata_o == {4'h0, ctl_q})
    else $error("control readback wrong");
  lr_with_bclk_a: assert property (
    lr_move |-> $changed(audio_bit_clock_out)) else $error("channel clock off bit edge");
  lr_phase_a: assert property (
    lr_move ##0 !$past(reg_wr_i) |-> audio_bit_clock_out == ctl_q[1])
    else $error("channel clock wrong bit edge");
  bclk_phase_a: assert property (
    $changed(audio_bit_clock_out) && !$past(reg_wr_i)
    |-> $past(divider_master_clock_in, 3) == ctl_q[0]) else $error("bit clock wrong edge");
endmodule
bind flacd_top flacd_asserts u_flacd_asserts (.*);
`default_nettype wire

// >>> verification/flacd_codec_model.sv
// board and codec side: master clock source and channel frame bit counter
`default_nettype none
module flacd_codec_model (
  input wire logic ref_clk_i,
  input wire logic loop_i,
  input wire logic mclk_i,
  input wire logic bclk_i,
  input wire logic lrclk_i,
  output logic mclk_o,
  output int bits_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic own_q = 1'b0;
  logic b_q = 1'b0;
  logic l_q = 1'b0;
  int cnt = 0;
  // slower than the loopback so the two sources are told apart
  always #600 own_q = ~own_q;
  assign mclk_o = loop_i ? mclk_i : own_q;
  // rising bit clock edges per channel half period
  always @(posedge ref_clk_i) begin
    b_q <= bclk_i;
    l_q <= lrclk_i;
    if (lrclk_i != l_q) begin
      bits_o <= cnt + int'(bclk_i && !b_q);
      cnt <= 0;
    end else begin
      cnt <= cnt + int'(bclk_i && !b_q);
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the audio clock divider
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic loop = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic ce = 1'b1;
  logic ivs = 1'b0;
  logic evs = 1'b0;
  logic [7:0] rdata;
  logic mclk, mi, bclk, lrclk;
  logic [7:0] ra[7] = '{8'h38, 8'h39, 8'h3a, 8'h30, 8'h36, 8'h33, 8'h3b};
  logic [7:0] re[7] = '{8'h03, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa[10] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a};
  logic [7:0] we[10] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h00, 8'h3f, 8'h3f, 8'h0f};
  logic [7:0] cc[4] = '{8'h08, 8'h0b, 8'h09, 8'h0a};
  int cd[4] = '{0, 2, 1, 1};
  int cl[4] = '{1, 3, 0, 2};
  int bits, n;
  int bad_count = 0;
  int samples_checked = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  flacd_top u_flacd_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .internal_vsync_i(ivs), .external_vsync_i(evs),
    .divider_master_clock_in(mi), .master_audio_clock_out(mclk),
    .audio_bit_clock_out(bclk), .channel_select_clock_out(lrclk));
  flacd_codec_model u_flacd_codec_model (.ref_clk_i(ref_clk_i), .loop_i(loop),
    .mclk_i(mclk), .bclk_i(bclk), .lrclk_i(lrclk), .mclk_o(mi), .bits_o(bits));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #10 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge ref_clk_i);
    #10 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    #10 addr = a;
    rd = 1'b1;
    @(posedge ref_clk_i);
    #10 rd = 1'b0;
    check("register", {8'h00, rdata}, {8'h00, e});
  endtask
  // counts whole cycles until the watched clock next changes
  task automatic half(input int w, output int k);
    logic v;
    v = (w == 0) ? bclk : (w == 1) ? lrclk : mclk;
    k = 0;
    while (((w == 0) ? bclk : (w == 1) ? lrclk : mclk) === v && k < 3000) begin
      #100 k++;
    end
  endtask
  // first toggle only aligns; both following halves checked for a square wave
  task automatic meas(input int w, input int e);
    half(w, n);
    repeat (2) begin
      half(w, n);
      check("half period", 16'(n), 16'(e));
    end
  endtask
  // field pulses on the internal (ext 0) or external (ext 1) vertical pin
  task automatic ramp(input logic [7:0] c, input logic ext);
    wr_reg(8'h3a, c);
    repeat (130) begin
      @(posedge ref_clk_i);
      #10 ivs = !ext;
      evs = ext;
      @(posedge ref_clk_i);
      #10 ivs = 1'b0;
      evs = 1'b0;
    end
  endtask
  // trim at +127 makes the master half period 2^22 / (4096 + 127), i.e. 993 or 994 cycles
  task automatic trimmed;
    half(2, n);
    half(2, n);
    check("trimmed half", 16'(n >= 993 && n <= 994), 16'h0001);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #10 nrst_i = 1'b1;
    foreach (ra[i]) rd_reg(ra[i], re[i]);
    ce = 1'b0;
    wr_reg(8'h38, 8'h05);
    ce = 1'b1;
    rd_reg(8'h38, 8'h03);
    for (int i = 0; i < 10; i++) begin
      wr_reg(wa[i], 8'hff);
      rd_reg(wa[i], we[i]);
    end
    wr_reg(8'h3a, 8'h08);
    wr_reg(8'h34, 8'h00);
    wr_reg(8'h35, 8'h00);
    wr_reg(8'h36, 8'h10);
    meas(2, 4);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h38, cd[c][7:0]);
      wr_reg(8'h39, cl[c][7:0]);
      wr_reg(8'h3a, cc[c]);
      meas(0, 8 * (cd[c] + 1));
      meas(1, 16 * (cd[c] + 1) * ((cl[c] == 0) ? 1 : cl[c]));
      check("bits per half", 16'(bits), 16'((cl[c] == 0) ? 1 : cl[c]));
    end
    loop = 1'b0;
    wr_reg(8'h36, 8'h00);
    meas(0, 24);
    wr_reg(8'h35, 8'h10);
    ramp(8'h00, 1'b0);
    trimmed();
    wr_reg(8'h3a, 8'h08);
    meas(2, 1024);
    ramp(8'h04, 1'b0);
    meas(2, 1024);
    ramp(8'h04, 1'b1);
    trimmed();
    print_verdict();
  end
endmodule
`default_nettype wire
